// *** design/pdf_pin_mux.v ***
// pin function mux for four port f pins and six port d pins
// What this block does
// - data-bus pins tri-state when bus idle
// - port f pins reset to data-bus function
// - port f data-bus unusable, only gpio works
// - each port f pin input or output
// - port f pullup bit n controls pin n
// - pin d0 gpio at reset, select cs2/can tx
// - pin d1 gpio at reset, select cs3/can rx
// - chip selects two, three tri-state when idle with bus drive control clear
// - chip selects four-seven tri-state, gpio at reset
// - chip selects come from memory interface unit
// - can receive input has internal pullup
// - port d pullup bit n controls pin n, except pin d1 in can rx mode, where the pullup is forced on
`timescale 1ns/100ps
`include "pdf_pin_mux_consts.vh"
module pdf_pin_mux (
  // clock and reset
  input wire clk,
  input wire srst,
  // configuration write port
  input wire cfgWrite,
  input wire [3:0] cfgSel,
  input wire [7:0] cfgData,
  // memory interface unit
  input wire busDriveControl,
  input wire busActive,
  input wire [7:2] chipSelectN,
  // second can controller
  input wire secondCanTransmit,
  output reg secondCanReceive,
  // port f pins
  input wire [3:0] pfPinIn,
  output reg [3:0] pfPinOut,
  output reg [3:0] pfPinOe,
  output reg [3:0] pfPullup,
  // port d pins
  input wire [5:0] pdPinIn,
  output reg [5:0] pdPinOut,
  output reg [5:0] pdPinOe,
  output reg [5:0] pdPullup,
  // gpio input readback
  output reg [3:0] pfGpioIn,
  output reg [5:0] pdGpioIn
);

  reg [3:0] pfPer;
  reg [3:0] pfDir;
  reg [3:0] pfData;
  reg [3:0] pfPull;
  reg [5:0] pdPer;
  reg [5:0] pdDir;
  reg [5:0] pdData;
  reg [5:0] pdPull;
  reg [7:0] sysPsel;
  wire [9:0] pinSync;
  reg [3:0] next_pfPinOut;
  reg [3:0] next_pfPinOe;
  reg [3:0] next_pfPullup;
  reg [5:0] next_pdPinOut;
  reg [5:0] next_pdPinOe;
  reg [5:0] next_pdPullup;
  reg next_secondCanReceive;
  reg csDrive;
  integer i;

  pdf_sync2 #(
    .WIDTH(10)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .asyncIn({pdPinIn, pfPinIn}),
    .syncOut(pinSync)
  );

  // configuration registers
  always @(posedge clk) begin
    if (srst) begin
      pfPer <= `PDF_RST_PF_PER;
      pfDir <= `PDF_RST_PF_DIR;
      pfData <= `PDF_RST_PF_DATA;
      pfPull <= `PDF_RST_PF_PULLUP;
      pdPer <= `PDF_RST_PD_PER;
      pdDir <= `PDF_RST_PD_DIR;
      pdData <= `PDF_RST_PD_DATA;
      pdPull <= `PDF_RST_PD_PULLUP;
      sysPsel <= `PDF_RST_SYS_PSEL;
    end else if (cfgWrite) begin
      case (cfgSel)
        `PDF_SEL_PF_PER: pfPer <= cfgData[3:0];
        `PDF_SEL_PF_DIR: pfDir <= cfgData[3:0];
        `PDF_SEL_PF_DATA: pfData <= cfgData[3:0];
        `PDF_SEL_PF_PULLUP: pfPull <= cfgData[3:0];
        `PDF_SEL_PD_PER: pdPer <= cfgData[5:0];
        `PDF_SEL_PD_DIR: pdDir <= cfgData[5:0];
        `PDF_SEL_PD_DATA: pdData <= cfgData[5:0];
        `PDF_SEL_PD_PULLUP: pdPull <= cfgData[5:0];
        `PDF_SEL_SYS_PSEL: sysPsel <= cfgData;
        default: sysPsel <= sysPsel;
      endcase
    end
  end

  // pin drive selection
  always @* begin
    csDrive = busActive || (busDriveControl == `PDF_DRV_ALWAYS);
    next_pfPullup = pfPull;
    next_pdPullup = pdPull;
    next_secondCanReceive = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      if (pfPer[i]) begin
        // data-bus owner does not exist here, so the pin just floats
        next_pfPinOut[i] = 1'b0;
        next_pfPinOe[i] = 1'b0;
      end else begin
        next_pfPinOut[i] = pfData[i];
        next_pfPinOe[i] = pfDir[i];
      end
    end
    for (i = 0; i < 6; i = i + 1) begin
      // gpio path ignores the peripheral select entirely
      next_pdPinOut[i] = pdData[i];
      next_pdPinOe[i] = pdDir[i];
      if (pdPer[i]) begin
        next_pdPinOut[i] = chipSelectN[i+2];
        next_pdPinOe[i] = csDrive;
      end
    end
    if (pdPer[0] && sysPsel[`PDF_PSEL_PIN0_BIT]) begin
      // open drain: only a dominant low is driven
      next_pdPinOut[0] = 1'b0;
      next_pdPinOe[0] = ~secondCanTransmit;
    end
    if (pdPer[1] && sysPsel[`PDF_PSEL_PIN1_BIT]) begin
      next_pdPinOut[1] = 1'b0;
      next_pdPinOe[1] = 1'b0;
      next_pdPullup[1] = 1'b1;
      next_secondCanReceive = pinSync[5];
    end
  end

  // registered outputs; reset leaves every pin undriven with pullups on
  always @(posedge clk) begin
    if (srst) begin
      pfPinOut <= 4'h0;
      pfPinOe <= 4'h0;
      pfPullup <= `PDF_RST_PF_PULLUP;
      pdPinOut <= 6'h00;
      pdPinOe <= 6'h00;
      pdPullup <= `PDF_RST_PD_PULLUP;
      secondCanReceive <= 1'b1;
      pfGpioIn <= 4'h0;
      pdGpioIn <= 6'h00;
    end else begin
      pfPinOut <= next_pfPinOut;
      pfPinOe <= next_pfPinOe;
      pfPullup <= next_pfPullup;
      pdPinOut <= next_pdPinOut;
      pdPinOe <= next_pdPinOe;
      pdPullup <= next_pdPullup;
      secondCanReceive <= next_secondCanReceive;
      pfGpioIn <= pinSync[3:0];
      pdGpioIn <= pinSync[9:4];
    end
  end

endmodule

// *** design/pdf_pin_mux_consts.vh ***
// constants for the port d / port f pin function mux
`ifndef PDF_PIN_MUX_CONSTS_VH
`define PDF_PIN_MUX_CONSTS_VH

// configuration select codes on cfgSel
`define PDF_SEL_PF_PER 4'h0
`define PDF_SEL_PF_DIR 4'h1
`define PDF_SEL_PF_DATA 4'h2
`define PDF_SEL_PF_PULLUP 4'h3
`define PDF_SEL_PD_PER 4'h4
`define PDF_SEL_PD_DIR 4'h5
`define PDF_SEL_PD_DATA 4'h6
`define PDF_SEL_PD_PULLUP 4'h7
`define PDF_SEL_SYS_PSEL 4'h8

// reset values
`define PDF_RST_PF_PER 4'hf
`define PDF_RST_PF_DIR 4'h0
`define PDF_RST_PF_DATA 4'h0
`define PDF_RST_PF_PULLUP 4'hf
`define PDF_RST_PD_PER 6'h00
`define PDF_RST_PD_DIR 6'h00
`define PDF_RST_PD_DATA 6'h00
`define PDF_RST_PD_PULLUP 6'h3f
`define PDF_RST_SYS_PSEL 8'h00

// system peripheral select field positions
`define PDF_PSEL_PIN0_BIT 4
`define PDF_PSEL_PIN1_BIT 5

// bus drive control value that keeps outputs driven while the bus is idle
`define PDF_DRV_ALWAYS 1'b1

`endif

// *** design/pdf_sync2.v ***
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pdf_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // asynchronous input and synchronised output
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // stage1 is read only by the second flop
  always @(posedge clk) begin
    if (srst) begin
      stage1 <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// *** sim/pdf_pin_mux_properties.sv ***
// port assertions for the pin mux
`timescale 1ns/100ps
module pdf_pin_mux_properties (
  // watched ports
  input wire clk, input wire srst, input wire cfgWrite, input wire busActive,
  input wire busDriveControl, input wire secondCanTransmit, input wire secondCanReceive,
  input wire [3:0] pfPinOe, input wire [3:0] pfPullup,
  input wire [5:0] pdPinOut, input wire [5:0] pdPinOe, input wire [5:0] pdPullup
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire busOn = busActive | busDriveControl;
  a_rst_quiet: assert property (disable iff (1'b0) srst |=> !pfPinOe && !pdPinOe)
    else $error("driven in reset");
  a_rst_pulls: assert property (disable iff (1'b0)
    srst |=> &{pfPullup, pdPullup, secondCanReceive}) else $error("pull off in reset");
  a_pf_dir_write: assert property (
    |(pfPinOe & ~$past(pfPinOe)) |-> $past(cfgWrite, 2)) else $error("pf drive");
  a_pull_write: assert property (
    $changed({pfPullup, pdPullup}) |-> $past(cfgWrite, 2)) else $error("pull moved");
  a_cs_idle_on: assert property (
    |(pdPinOe[5:1] & ~$past(pdPinOe[5:1])) && !$past(cfgWrite, 2) |-> $past(busOn))
    else $error("cs on");
  a_cs_idle_off: assert property (
    |(~pdPinOe[5:2] & $past(pdPinOe[5:2])) && !$past(cfgWrite, 2) |-> !$past(busOn))
    else $error("cs off");
  a_can_tx_low: assert property (
    $rose(pdPinOe[0]) && !$past(cfgWrite, 2) && !$past(busOn)
    |-> !pdPinOut[0] && !$past(secondCanTransmit)) else $error("tx");
  a_can_rx_pull: assert property (!secondCanReceive |-> pdPullup[1] && !pdPinOe[1])
    else $error("rx pull");
endmodule
bind pdf_pin_mux pdf_pin_mux_properties props_u (.*);

// *** sim/pdf_far_model.sv ***
// memory interface and can controller stand-in
`timescale 1ns/100ps
module pdf_far_model #(
  parameter REGION = 6'h04
) (
  input wire clk,
  input wire access,
  input wire canBit,
  output reg busActive = 1'b0,
  output reg [7:2] chipSelectN = 6'h3f,
  output reg secondCanTransmit = 1'b1
);
  always @(posedge clk) begin
    busActive <= access;
    chipSelectN <= access ? ~REGION : 6'h3f;
    secondCanTransmit <= canBit;
  end
endmodule

// *** sim/pdf_pin_mux_test.sv ***
// self-checking bench for the pin mux
`timescale 1ns/100ps
module pdf_pin_mux_test;
  reg clk = 0, srst = 1, cfgWrite = 0, busDriveControl = 0, access = 0, canBit = 1;
  reg [3:0] cfgSel = 0, pfExt = 4'hf;
  reg [7:0] cfgData = 0;
  reg [5:0] pdExt = 6'h3d;
  reg [31:0] rows [0:8];
  integer miscompares = 0, nChecks = 0, cyc = 0, i;
  wire busActive, secondCanTransmit, secondCanReceive;
  wire [7:2] chipSelectN;
  wire [3:0] pfPinOut, pfPinOe, pfPullup, pfGpioIn;
  wire [5:0] pdPinOut, pdPinOe, pdPullup, pdGpioIn;
  // undriven pins follow what the outside world holds on them
  wire [3:0] pfPinIn = pfPinOe & pfPinOut | ~pfPinOe & pfExt;
  wire [5:0] pdPinIn = pdPinOe & pdPinOut | ~pdPinOe & pdExt;
  pdf_far_model far_u (.*);
  pdf_pin_mux dut_u (.*);
  always #12.5 clk = ~clk;
  task cmp(input [31:0] seen, input [31:0] exp);
    begin
      nChecks = nChecks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [11:0] sd);
    begin
      {cfgSel, cfgData} = sd;
      cfgWrite = 1;
      step(1);
      cfgWrite = 0;
      step(1);
    end
  endtask
  task results;
    begin
      if (miscompares == 0 && nChecks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      miscompares = miscompares + 1;
      results;
    end
  end
  initial begin
    // select, data, then pf oe, pd oe, pf pulls, pd pulls
    rows[0] = 32'h10f0_03ff;
    rows[1] = 32'h000f_03ff;
    rows[2] = 32'h30ef_03bf;
    rows[3] = 32'h53ff_ffbf;
    rows[4] = 32'h739f_ffb9;
    rows[5] = 32'h830f_ffb9;
    rows[6] = 32'h43ff_03bb;
    rows[7] = 32'h800f_03b9;
    rows[8] = 32'h9fff_03b9;
    step(3);
    srst = 0;
    for (i = 0; i < 9; i = i + 1) begin
      wr(rows[i][31:20]);
      cmp({pfPinOe, pdPinOe, pfPullup, pdPullup}, rows[i][19:0]);
    end
    access = 1;
    step(2);
    cmp({pdPinOe, pdPinOut}, 12'hffb);
    access = 0;
    busDriveControl = 1;
    step(2);
    cmp({pdPinOe, pdPinOut}, 12'hfff);
    busDriveControl = 0;
    step(1);
    cmp(pdPinOe, 6'h00);
    wr(12'h830);
    canBit = 0;
    step(2);
    cmp({pdPinOe[1:0], pdPinOut[0], secondCanReceive, pdPullup[1]}, 5'h09);
    canBit = 1;
    srst = 1;
    step(2);
    cmp({pfPinOe, pdPinOe, pfPullup, pdPullup, secondCanReceive}, 21'h00_07ff);
    srst = 0;
    pfExt = 4'h5;
    step(4);
    cmp(pfGpioIn, 4'h5);
    cmp({pdGpioIn, pfPinOut}, 10'h3d0);
    results;
  end
endmodule
